// File: src/wwdt_top.sv
/*
  Windowed watchdog with APB registers, prescaler, postscaler, window
  check, power-save handling and a level interrupt.
  Assumes the core gives one-cycle pulses on I_CLK_SYS for clear,
  power-save entry, clock-switch completion and wake, and that the
  system clock keeps running while the core sleeps.
*/
`timescale 1ns/10ps
`include "wwdt_consts.svh"
module wwdt_top #(
  parameter int ADDR_W = 12,
  parameter int POST_W = 15
) (
  // Clock and resets
  input wire logic I_CLK_SYS,
  input wire logic I_SYS_RST,
  input wire logic I_DEV_RST,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [ADDR_W-1:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic O_PREADY,
  output logic [31:0] O_PRDATA,
  output logic O_PSLVERR,
  // Low-power RC oscillator
  input wire logic I_LOW_POWER_RC_OSC,
  output logic O_LOW_POWER_RC_OSC_EN,
  // Core events
  input wire logic I_DOG_CLEAR_INSTR,
  input wire logic I_POWER_SAVE_INSTR,
  input wire logic I_POWER_SAVE_SLEEP,
  input wire logic I_OSC_SWITCH_DONE,
  input wire logic I_WAKE_EXIT,
  // Results
  output logic O_DEV_RESET,
  output logic O_WAKE,
  output logic O_IRQ,
  output wwdt_pkg::wwdt_pwr_t O_POWER_STATE
);
  import wwdt_pkg::*;

  localparam int PRE_SHORT_LOG = $clog2(`WWDT_PRE_SHORT_DIV);
  localparam int PRE_LONG_LOG = $clog2(`WWDT_PRE_LONG_DIV);
  localparam int PRE_W = PRE_LONG_LOG;
  localparam int ELAP_W = POST_W + PRE_W;

  if (ADDR_W < 5 || POST_W != 15 || PRE_W != 7 || PRE_SHORT_LOG != 5)
  begin : g_chk
    $error("wwdt_top: unsupported width or divider setting");
  end

  // ****************************************
  // Declarations
  // ****************************************
  logic [7:0] cfg_r;
  logic soft_en_r;
  logic tmo_flag_r;
  logic sleep_flag_r;
  logic idle_flag_r;
  logic [2:0] irq_stat_r;
  logic [2:0] irq_en_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic dev_reset_r;
  logic wake_r;
  wwdt_pwr_t pwr_r;
  logic osc_s1_r;
  logic osc_s2_r;
  logic osc_s3_r;
  logic osc_tick;
  logic [3:0] post_sel;
  logic pre_sel;
  logic win_dis;
  logic perm_en;
  logic dog_en;
  logic run;
  logic clear_ok;
  logic early;
  logic early_fault;
  logic timeout;
  logic dev_reset_nxt;
  logic wake_nxt;
  logic ps_enter;
  logic pwr_exit;
  logic restart;
  logic [PRE_W-1:0] pre_last;
  logic [PRE_W-1:0] pre_cnt;
  logic pre_wrap;
  logic [POST_W-1:0] post_last;
  logic [POST_W-1:0] post_cnt;
  logic [ELAP_W-1:0] elapsed;
  logic [ELAP_W-1:0] win_start;
  logic [4:0] win_shamt;
  logic setup;
  logic acc_wr;
  logic [ADDR_W-1:0] offs;
  logic [31:0] rd_mux;
  logic rd_err;
  logic [7:0] rctl_view;

  // ****************************************
  // Configuration fields
  // ****************************************
  assign post_sel = cfg_r[`WWDT_CFG_POST_LSB +: 4];
  assign pre_sel = cfg_r[`WWDT_CFG_PRE_BIT];
  assign win_dis = cfg_r[`WWDT_CFG_WINOFF_BIT];
  assign perm_en = cfg_r[`WWDT_CFG_PERM_BIT];
  assign dog_en = perm_en | soft_en_r;
  // Oscillator stays on whenever the dog may count
  assign O_LOW_POWER_RC_OSC_EN = dog_en;
  assign run = (pwr_r == WWDT_RUN);

  // ****************************************
  // Oscillator edge detection
  // ****************************************
  // Oscillator is asynchronous; first flop feeds only the second
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_SYS_RST)
    begin
      osc_s1_r <= 1'b0;
      osc_s2_r <= 1'b0;
      osc_s3_r <= 1'b0;
    end
    else
    begin
      osc_s1_r <= I_LOW_POWER_RC_OSC;
      osc_s2_r <= osc_s1_r;
      osc_s3_r <= osc_s2_r;
    end
  end

  assign osc_tick = osc_s2_r & ~osc_s3_r;

  // ****************************************
  // Prescaler and postscaler
  // ****************************************
  // Bit one picks the long divider
  assign pre_last = pre_sel ? PRE_W'(`WWDT_PRE_LONG_DIV - 1)
                            : PRE_W'(`WWDT_PRE_SHORT_DIV - 1);
  // Ratio doubles with each code step, 1111 being the longest
  assign post_last = POST_W'((16'h1 << post_sel) - 16'h1);

  wwdt_scaler #(
    .W(PRE_W)
  ) u_pre (
    .i_clk(I_CLK_SYS),
    .i_restart(restart),
    .i_step(osc_tick),
    .i_last(pre_last),
    .o_count(pre_cnt),
    .o_wrap(pre_wrap)
  );

  wwdt_scaler #(
    .W(POST_W)
  ) u_post (
    .i_clk(I_CLK_SYS),
    .i_restart(restart),
    .i_step(pre_wrap),
    .i_last(post_last),
    .o_count(post_cnt),
    .o_wrap(timeout)
  );

  // ****************************************
  // Window check
  // ****************************************
  // Ticks since restart, against three quarters of the period
  assign elapsed = pre_sel ? {post_cnt, pre_cnt}
                           : ELAP_W'({post_cnt, pre_cnt[PRE_SHORT_LOG-1:0]});
  assign win_shamt = 5'(post_sel) + (pre_sel ? 5'(PRE_LONG_LOG - 2)
                                             : 5'(PRE_SHORT_LOG - 2));
  assign win_start = ELAP_W'(3) << win_shamt;
  assign early = elapsed < win_start;

  // ****************************************
  // Events
  // ****************************************
  // Clear only counts while the core runs
  assign clear_ok = I_DOG_CLEAR_INSTR & dog_en & run;
  assign early_fault = clear_ok & ~win_dis & early;
  // Timeout beats a clear arriving in the same cycle
  assign dev_reset_nxt = (timeout & run) | early_fault;
  assign wake_nxt = timeout & ~run;
  assign ps_enter = I_POWER_SAVE_INSTR & run;
  assign pwr_exit = (I_WAKE_EXIT & ~run) | wake_nxt;
  // Disabled dog is held at zero so it restarts fresh when enabled
  assign restart = I_SYS_RST | I_DEV_RST | ~dog_en | I_OSC_SWITCH_DONE |
                   ps_enter | pwr_exit | clear_ok |
                   dev_reset_nxt;

  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_SYS_RST)
    begin
      dev_reset_r <= 1'b0;
      wake_r <= 1'b0;
    end
    else
    begin
      dev_reset_r <= dev_reset_nxt;
      wake_r <= wake_nxt;
    end
  end

  assign O_DEV_RESET = dev_reset_r;
  assign O_WAKE = wake_r;

  // ****************************************
  // Power state
  // ****************************************
  // Wake resumes after the power-save instruction; no reset is issued
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_SYS_RST || I_DEV_RST)
      pwr_r <= WWDT_RUN;
    else
    begin
      unique case (pwr_r)
        WWDT_RUN:
          if (ps_enter)
            pwr_r <= I_POWER_SAVE_SLEEP ? WWDT_SLEEP : WWDT_IDLE;
        WWDT_SLEEP,
        WWDT_IDLE:
          if (pwr_exit)
            pwr_r <= WWDT_RUN;
        default:
          pwr_r <= WWDT_RUN;
      endcase
    end
  end

  assign O_POWER_STATE = pwr_r;

  // ****************************************
  // APB decode
  // ****************************************
  // Zero wait state; read data is captured in the setup cycle
  assign setup = I_PSEL & ~I_PENABLE;
  assign O_PREADY = I_PSEL & I_PENABLE;
  assign acc_wr = I_PSEL & I_PENABLE & I_PWRITE;
  assign offs = {I_PADDR[ADDR_W-1:2], 2'b00};
  assign rctl_view = {2'b00, soft_en_r, tmo_flag_r, sleep_flag_r,
                      idle_flag_r, 2'b00};

  always_comb
  begin
    rd_mux = 32'h0;
    rd_err = 1'b0;
    unique case (offs)
      ADDR_W'(`WWDT_ADDR_CFG): rd_mux = {24'h0, cfg_r};
      ADDR_W'(`WWDT_ADDR_RCTL): rd_mux = {24'h0, rctl_view};
      ADDR_W'(`WWDT_ADDR_ISTAT): rd_mux = {29'h0, irq_stat_r};
      ADDR_W'(`WWDT_ADDR_IEN): rd_mux = {29'h0, irq_en_r};
      ADDR_W'(`WWDT_ADDR_ICLR): rd_mux = 32'h0;
      ADDR_W'(`WWDT_ADDR_COUNT): rd_mux = {10'h0, post_cnt, pre_cnt};
      default: rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_SYS_RST)
    begin
      prdata_r <= 32'h0;
      pslverr_r <= 1'b0;
    end
    else if (setup)
    begin
      prdata_r <= I_PWRITE ? 32'h0 : rd_mux;
      pslverr_r <= rd_err;
    end
  end

  assign O_PRDATA = prdata_r;
  assign O_PSLVERR = pslverr_r & I_PSEL & I_PENABLE;

  // ****************************************
  // Configuration word
  // ****************************************
  // Survives device resets; only the system reset restores it
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_SYS_RST)
      cfg_r <= `WWDT_CFG_RST;
    else if (acc_wr && offs == ADDR_W'(`WWDT_ADDR_CFG))
      cfg_r <= {I_PWDATA[7:6], 1'b0, I_PWDATA[4:0]};
  end

  // ****************************************
  // Reset control bits
  // ****************************************
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_SYS_RST || I_DEV_RST)
      soft_en_r <= 1'b0;
    else if (acc_wr && offs == ADDR_W'(`WWDT_ADDR_RCTL))
      // Permanent enable makes a clearing write a no-op
      soft_en_r <= I_PWDATA[`WWDT_RC_SOFT_BIT] |
                   (perm_en & soft_en_r);
  end

  // Flags clear on a zero write; a set in the same cycle wins
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_SYS_RST)
    begin
      tmo_flag_r <= 1'b0;
      sleep_flag_r <= 1'b0;
      idle_flag_r <= 1'b0;
    end
    else
    begin
      // Kept across device reset so software can see why it restarted
      if (timeout || early_fault)
        tmo_flag_r <= 1'b1;
      else if (acc_wr && offs == ADDR_W'(`WWDT_ADDR_RCTL))
        tmo_flag_r <= tmo_flag_r & I_PWDATA[`WWDT_RC_TMO_BIT];
      // Hardware never clears these after a wake
      if (ps_enter && I_POWER_SAVE_SLEEP)
        sleep_flag_r <= 1'b1;
      else if (acc_wr && offs == ADDR_W'(`WWDT_ADDR_RCTL))
        sleep_flag_r <= sleep_flag_r &
                        I_PWDATA[`WWDT_RC_SLEEP_BIT];
      if (ps_enter && !I_POWER_SAVE_SLEEP)
        idle_flag_r <= 1'b1;
      else if (acc_wr && offs == ADDR_W'(`WWDT_ADDR_RCTL))
        idle_flag_r <= idle_flag_r & I_PWDATA[`WWDT_RC_IDLE_BIT];
    end
  end

  // ****************************************
  // Interrupt status, enable and clear
  // ****************************************
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_SYS_RST)
      irq_en_r <= `WWDT_IRQ_RST;
    else if (acc_wr && offs == ADDR_W'(`WWDT_ADDR_IEN))
      irq_en_r <= I_PWDATA[2:0];
  end

  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_SYS_RST)
      irq_stat_r <= `WWDT_IRQ_RST;
    else
    begin
      if (acc_wr && offs == ADDR_W'(`WWDT_ADDR_ICLR))
        irq_stat_r <= irq_stat_r & ~I_PWDATA[2:0];
      if (timeout)
        irq_stat_r[`WWDT_IRQ_TMO_BIT] <= 1'b1;
      if (early_fault)
        irq_stat_r[`WWDT_IRQ_WIN_BIT] <= 1'b1;
      if (wake_nxt)
        irq_stat_r[`WWDT_IRQ_WAKE_BIT] <= 1'b1;
    end
  end

  assign O_IRQ = |(irq_stat_r & irq_en_r);

endmodule // wwdt_top

// File: src/wwdt_consts.svh
/*
  Offsets, field positions, reset values and timing figures of the
  windowed watchdog. Assumes the includer wants plain `define constants.
*/
// How it works
// - Low-power RC oscillator clocks counter; enable forces on
// - Prescaler divides by 32 or 128
// - Base period 1 ms or 4 ms
// - Four-bit postscaler field, sixteen ratios
// - Resets, clock switch, power-save restart counters
// - Clear instruction restarts counter and scalers
// - Timeout in sleep or idle wakes core
// - Permanent enable keeps watchdog always running
// - Timeout sets sticky flag until software clears
// - Otherwise soft enable bit gates the watchdog
// - Soft enable cleared by every device reset
// - Early clear in window mode resets device
// - Prescale bit one selects divide-by-128
// - Code 1111 is 1:32768, halving per step
// - Window-disable one means non-window operation
`ifndef WWDT_CONSTS_SVH
`define WWDT_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define WWDT_ADDR_CFG 12'h000
`define WWDT_ADDR_RCTL 12'h004
`define WWDT_ADDR_ISTAT 12'h008
`define WWDT_ADDR_IEN 12'h00c
`define WWDT_ADDR_ICLR 12'h010
`define WWDT_ADDR_COUNT 12'h014

// ****************************************
// Field positions and reset values
// ****************************************
`define WWDT_CFG_POST_LSB 0
`define WWDT_CFG_PRE_BIT 4
`define WWDT_CFG_WINOFF_BIT 6
`define WWDT_CFG_PERM_BIT 7
`define WWDT_CFG_RST 8'hdf
`define WWDT_RC_SOFT_BIT 5
`define WWDT_RC_TMO_BIT 4
`define WWDT_RC_SLEEP_BIT 3
`define WWDT_RC_IDLE_BIT 2
`define WWDT_IRQ_TMO_BIT 0
`define WWDT_IRQ_WIN_BIT 1
`define WWDT_IRQ_WAKE_BIT 2
`define WWDT_IRQ_RST 3'h0

// ****************************************
// Timing
// ****************************************
`define WWDT_OSC_HZ 32000
`define WWDT_TBASE_SHORT_US 1000
`define WWDT_TBASE_LONG_US 4000
`define WWDT_PRE_SHORT_DIV (`WWDT_OSC_HZ*`WWDT_TBASE_SHORT_US/1000000)
`define WWDT_PRE_LONG_DIV (`WWDT_OSC_HZ*`WWDT_TBASE_LONG_US/1000000)

`endif

// File: src/wwdt_pkg.sv
/*
  Types of the windowed watchdog.
  Assumes nothing of its surroundings.
*/
package wwdt_pkg;

  // ****************************************
  // Power mode of the core as seen by the dog
  // ****************************************
  typedef enum logic [1:0] {
    WWDT_RUN,
    WWDT_SLEEP,
    WWDT_IDLE
  } wwdt_pwr_t;

endpackage

// File: src/wwdt_scaler.sv
/*
  Restartable divider stage: counts steps and wraps after i_last.
  Assumes i_restart and i_step are synchronous to i_clk.
*/
`timescale 1ns/10ps
module wwdt_scaler #(
  parameter int W = 7
) (
  // Clock and restart
  input wire logic i_clk,
  input wire logic i_restart,
  // Counting
  input wire logic i_step,
  input wire logic [W-1:0] i_last,
  output logic [W-1:0] o_count,
  output logic o_wrap
);

  if (W < 1)
  begin : g_chk
    $error("wwdt_scaler: W must be at least 1");
  end

  logic [W-1:0] count_r;

  assign o_count = count_r;
  assign o_wrap = i_step & (count_r == i_last);

  always_ff @(posedge i_clk)
  begin
    if (i_restart)
      count_r <= '0;
    else if (o_wrap)
      count_r <= '0;
    else if (i_step)
      count_r <= count_r + {{(W-1){1'b0}}, 1'b1};
  end

endmodule // wwdt_scaler

// File: tb/wwdt_top_properties.sv
/*
  Checker of the watchdog's reset, wake and power-state outputs.
  Assumes it is bound to wwdt_top and sees only that module's ports.
*/
`timescale 1ns/10ps
module wwdt_top_chk (
  // Clock and resets
  input wire logic I_CLK_SYS,
  input wire logic I_SYS_RST,
  input wire logic I_DEV_RST,
  // Core events
  input wire logic I_POWER_SAVE_INSTR,
  input wire logic I_POWER_SAVE_SLEEP,
  input wire logic I_WAKE_EXIT,
  // Results
  input wire logic O_LOW_POWER_RC_OSC_EN,
  input wire logic O_DEV_RESET,
  input wire logic O_WAKE,
  input wire wwdt_pkg::wwdt_pwr_t O_POWER_STATE
);
  import wwdt_pkg::*;
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (I_SYS_RST);
  sequence s_enter_save;
    O_POWER_STATE == WWDT_RUN && I_POWER_SAVE_INSTR && !I_DEV_RST;
  endsequence
  sequence s_leave_save;
    $past(O_POWER_STATE) != WWDT_RUN && O_POWER_STATE == WWDT_RUN;
  endsequence
  a_reset_pulse: assert property (
    O_DEV_RESET |=> !O_DEV_RESET)
    else $error("device reset longer than one cycle");
  a_reset_in_run: assert property (
    O_DEV_RESET |-> $past(O_POWER_STATE) == WWDT_RUN)
    else $error("device reset raised while saving power");
  a_wake_pulse: assert property (
    O_WAKE |=> !O_WAKE)
    else $error("wake longer than one cycle");
  a_wake_resumes: assert property (
    O_WAKE |-> s_leave_save)
    else $error("wake without return to run");
  a_leave_cause: assert property (
    s_leave_save |-> O_WAKE || $past(I_WAKE_EXIT) || $past(I_DEV_RST))
    else $error("left power save without cause");
  a_save_entry: assert property (
    s_enter_save |=> O_POWER_STATE ==
      ($past(I_POWER_SAVE_SLEEP) ? WWDT_SLEEP : WWDT_IDLE))
    else $error("power save entry not taken");
  a_dev_rst_run: assert property (
    I_DEV_RST |=> O_POWER_STATE == WWDT_RUN)
    else $error("device reset left power save state");
  a_exit_run: assert property (
    O_POWER_STATE != WWDT_RUN && I_WAKE_EXIT |=> O_POWER_STATE == WWDT_RUN)
    else $error("exit did not return to run");
  a_osc_after_boot: assert property (
    $past(I_SYS_RST) |-> O_LOW_POWER_RC_OSC_EN)
    else $error("oscillator off after system reset");
endmodule // wwdt_top_chk

bind wwdt_top wwdt_top_chk wwdt_top_chk_inst (
  .I_CLK_SYS, .I_SYS_RST, .I_DEV_RST, .I_POWER_SAVE_INSTR,
  .I_POWER_SAVE_SLEEP, .I_WAKE_EXIT, .O_LOW_POWER_RC_OSC_EN,
  .O_DEV_RESET, .O_WAKE, .O_POWER_STATE
);

// File: tb/tb_top.sv
/*
  Self-checking bench of the windowed watchdog, driven over APB.
  Assumes wwdt_top, its package and header, and the bound checker.
*/
`timescale 1ns/10ps
`include "wwdt_consts.svh"
module tb_top;
  import wwdt_pkg::*;
  localparam logic [4:0] CLR = 5'h01, PSV = 5'h02, OSW = 5'h04;
  localparam logic [4:0] WEX = 5'h08, DRS = 5'h10;
  logic I_CLK_SYS = 1'b0;
  logic I_SYS_RST = 1'b1;
  logic I_PSEL = 1'b0, I_PENABLE = 1'b0, I_PWRITE = 1'b0;
  logic I_LOW_POWER_RC_OSC = 1'b0, I_POWER_SAVE_SLEEP = 1'b0;
  logic [11:0] I_PADDR = 12'h000;
  logic [31:0] I_PWDATA = 32'h0, O_PRDATA, rd;
  logic O_PREADY, O_PSLVERR, O_LOW_POWER_RC_OSC_EN, O_DEV_RESET;
  logic O_WAKE, O_IRQ, err;
  wwdt_pwr_t O_POWER_STATE;
  logic [4:0] ev = 5'h00;
  logic [1:0] ph = 2'h0;
  logic [7:0] cfgs [4] = '{8'hc0, 8'hc1, 8'hd0, 8'hd2};
  logic [4:0] rs [2] = '{OSW, DRS};
  int n_errors = 0, n_compared = 0, cyc, n;
  wire I_DOG_CLEAR_INSTR = ev[0];
  wire I_POWER_SAVE_INSTR = ev[1];
  wire I_OSC_SWITCH_DONE = ev[2];
  wire I_WAKE_EXIT = ev[3];
  wire I_DEV_RST = ev[4];

  wwdt_top wwdt_top_inst (
    .I_CLK_SYS, .I_SYS_RST, .I_DEV_RST, .I_PSEL, .I_PENABLE, .I_PWRITE,
    .I_PADDR, .I_PWDATA, .O_PREADY, .O_PRDATA, .O_PSLVERR,
    .I_LOW_POWER_RC_OSC, .O_LOW_POWER_RC_OSC_EN, .I_DOG_CLEAR_INSTR,
    .I_POWER_SAVE_INSTR, .I_POWER_SAVE_SLEEP, .I_OSC_SWITCH_DONE,
    .I_WAKE_EXIT, .O_DEV_RESET, .O_WAKE, .O_IRQ, .O_POWER_STATE
  );

  always #5 I_CLK_SYS = ~I_CLK_SYS;
  // Oscillator period of eight clocks keeps timeouts at 256 to 4096 cycles
  always @(posedge I_CLK_SYS)
  begin
    ph <= ph + 2'h1;
    if (ph == 2'h3)
      I_LOW_POWER_RC_OSC <= ~I_LOW_POWER_RC_OSC;
  end

  // ****************
  // Tasks
  // ****************
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge I_CLK_SYS);
    I_PSEL <= 1'b1;
    I_PWRITE <= w;
    I_PADDR <= a;
    I_PWDATA <= d;
    @(posedge I_CLK_SYS);
    I_PENABLE <= 1'b1;
    @(posedge I_CLK_SYS);
    while (O_PREADY !== 1'b1)
      @(posedge I_CLK_SYS);
    rd = O_PRDATA;
    err = O_PSLVERR;
    I_PSEL <= 1'b0;
    I_PENABLE <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, e);
    n_compared++;
    if (got !== e)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, e);
    end
  endtask

  task automatic chk_t(input int got, lo, hi);
    n_compared++;
    if (got < lo || got > hi)
    begin
      n_errors++;
      $display("mismatch at %0t: %0d cycles, want %0d..%0d", $time, got,
               lo, hi);
    end
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] m, e);
    apb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask

  task automatic pulse(input logic [4:0] m);
    @(posedge I_CLK_SYS);
    ev <= m;
    @(posedge I_CLK_SYS);
    ev <= 5'h00;
  endtask

  // Cycles from now until the chosen output pulses
  task automatic span(input logic w, input int lo, hi);
    cyc = 0;
    do
    begin
      @(posedge I_CLK_SYS);
      cyc++;
    end
    while ((w ? O_WAKE : O_DEV_RESET) !== 1'b1);
    chk_t(cyc, lo, hi);
  endtask

  task automatic conclude;
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ****************
  // Tests
  // ****************
  initial
  begin
    repeat (2) @(posedge I_CLK_SYS);
    I_SYS_RST <= 1'b0;
    rchk(`WWDT_ADDR_CFG, 32'hff, 32'hdf);
    rchk(`WWDT_ADDR_RCTL, 32'h3c, 32'h0);
    chk(O_LOW_POWER_RC_OSC_EN, 1'b1);
    rchk(12'h018, 32'hffffffff, 32'h0);
    chk(err, 1'b1);
    $display("reset test done");
    foreach (cfgs[i])
    begin
      n = ((cfgs[i][4] ? 128 : 32) << cfgs[i][3:0]) * 8;
      apb(1'b1, `WWDT_ADDR_CFG, {24'h0, cfgs[i]});
      pulse(CLR);
      span(1'b0, n - 12, n + 12);
    end
    rchk(`WWDT_ADDR_RCTL, 32'h10, 32'h10);
    chk(O_IRQ, 1'b0);
    apb(1'b1, `WWDT_ADDR_IEN, 32'h1);
    @(posedge I_CLK_SYS);
    chk(O_IRQ, 1'b1);
    apb(1'b1, `WWDT_ADDR_ICLR, 32'h1);
    @(posedge I_CLK_SYS);
    chk(O_IRQ, 1'b0);
    apb(1'b1, `WWDT_ADDR_RCTL, 32'h0);
    rchk(`WWDT_ADDR_RCTL, 32'h10, 32'h0);
    $display("period test done");
    apb(1'b1, `WWDT_ADDR_CFG, 32'h80);
    pulse(OSW);
    repeat (40) @(posedge I_CLK_SYS);
    pulse(CLR);
    span(1'b0, 1, 2);
    rchk(`WWDT_ADDR_ISTAT, 32'h2, 32'h2);
    repeat (220) @(posedge I_CLK_SYS);
    pulse(CLR);
    span(1'b0, 244, 268);
    $display("window test done");
    apb(1'b1, `WWDT_ADDR_CFG, 32'hc0);
    for (int s = 0; s < 2; s++)
    begin
      apb(1'b1, `WWDT_ADDR_RCTL, 32'h0);
      I_POWER_SAVE_SLEEP <= s[0];
      pulse(PSV);
      span(1'b1, 244, 268);
      chk(O_POWER_STATE, WWDT_RUN);
      rchk(`WWDT_ADDR_RCTL, 32'h1c, s ? 32'h18 : 32'h14);
    end
    rchk(`WWDT_ADDR_ISTAT, 32'h4, 32'h4);
    pulse(PSV);
    repeat (80) @(posedge I_CLK_SYS);
    pulse(WEX);
    span(1'b0, 244, 268);
    foreach (rs[i])
    begin
      repeat (150) @(posedge I_CLK_SYS);
      pulse(rs[i]);
      span(1'b0, 244, 268);
    end
    $display("power save test done");
    apb(1'b1, `WWDT_ADDR_CFG, 32'h40);
    @(posedge I_CLK_SYS);
    chk(O_LOW_POWER_RC_OSC_EN, 1'b0);
    cyc = 0;
    repeat (400) @(posedge I_CLK_SYS) cyc += O_DEV_RESET;
    chk_t(cyc, 0, 0);
    apb(1'b1, `WWDT_ADDR_RCTL, 32'h20);
    span(1'b0, 244, 268);
    pulse(DRS);
    rchk(`WWDT_ADDR_RCTL, 32'h20, 32'h0);
    rchk(`WWDT_ADDR_COUNT, 32'hffffffff, 32'h0);
    apb(1'b1, `WWDT_ADDR_CFG, 32'hc0);
    apb(1'b1, `WWDT_ADDR_RCTL, 32'h20);
    apb(1'b1, `WWDT_ADDR_RCTL, 32'h0);
    rchk(`WWDT_ADDR_RCTL, 32'h20, 32'h20);
    chk(O_LOW_POWER_RC_OSC_EN, 1'b1);
    pulse(DRS);
    span(1'b0, 244, 268);
    $display("enable test done");
    conclude;
  end

  initial
  begin
    #300us;
    n_errors++;
    $display("mismatch at %0t: run timed out", $time);
    conclude;
  end
endmodule // tb_top
